// ---- pomsr_defines.svh ----
/*
  Offsets, field positions, widths and reset values of the output mux and
  status register bank. Included by the register bank and the shared package.
*/
`ifndef POMSR_DEFINES_SVH
`define POMSR_DEFINES_SVH

`define POMSR_ADDR_W 5
`define POMSR_DATA_W 24
`define POMSR_OFS_CHANNELS 5'h0c
`define POMSR_OFS_PINCTL 5'h0f
`define POMSR_OFS_RSVD_A 5'h10
`define POMSR_OFS_RSVD_B 5'h11
`define POMSR_OFS_STATUS 5'h12
`define POMSR_OFS_SELFTEST 5'h13
`define POMSR_CHAN_W 14
`define POMSR_CHAN_RST 14'h0000
`define POMSR_PINCTL_W 10
`define POMSR_PINCTL_RST 10'h001
`define POMSR_SEL_LSB 0
`define POMSR_SEL_MSB 4
`define POMSR_TEST_BIT 5
`define POMSR_HOLDMUX_BIT 6
`define POMSR_KEEPDRV_BIT 7
`define POMSR_PFET_BIT 8
`define POMSR_NFET_BIT 9
`define POMSR_SIG_W 16
`define POMSR_BUSY_BIT 16

`endif

// ---- pomsr_host.sv ----
/*
  Serial framing host model: one-cycle write and read strobes.
  Assumes strobes are sampled on the rising edge of clk.
*/
`timescale 1ns/1ns
`default_nettype none
module pomsr_host (
  // Clock
  input wire logic clk,
  // Register access
  output logic reg_wr,
  output logic reg_rd,
  output pomsr_pkg::pomsr_addr_t reg_addr,
  output pomsr_pkg::pomsr_data_t reg_wdata,
  input wire pomsr_pkg::pomsr_data_t reg_rdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 24'h000000;
  end
  task automatic wr(input pomsr_pkg::pomsr_addr_t a, input pomsr_pkg::pomsr_data_t d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data lands on the edge that takes the strobe and stands after it
  task automatic rd(input pomsr_pkg::pomsr_addr_t a, output pomsr_pkg::pomsr_data_t d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask : rd
endmodule : pomsr_host
`default_nettype wire

// ---- pomsr_pkg.sv ----
/*
  Types shared by the output mux and status register bank.
  Assumes the defines header is compiled first.
*/
`include "pomsr_defines.svh"
package pomsr_pkg;
  typedef logic [4:0] pomsr_sel_t;
  typedef logic [`POMSR_ADDR_W-1:0] pomsr_addr_t;
  typedef logic [`POMSR_DATA_W-1:0] pomsr_data_t;
endpackage : pomsr_pkg

// ---- pomsr_regs.sv ----
/*
  Register bank for the channel count, output pin selector and controls,
  and the read-only status and self-test registers.
  Assumes the serial framing gives one-cycle write/read strobes with an
  address on clk, and that all status sources are synchronous to clk.
*/
`timescale 1ns/1ns
`default_nettype none
`include "pomsr_defines.svh"
module pomsr_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register access from the serial framing
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire pomsr_pkg::pomsr_addr_t reg_addr,
  input wire pomsr_pkg::pomsr_data_t reg_wdata,
  output logic [`POMSR_DATA_W-1:0] reg_rdata,
  // Serial data-out pin control
  input wire logic serial_rd_active,
  input wire logic serial_dout,
  input wire logic gpo_enable,
  output logic dataout_o,
  output logic dataout_oe_n,
  output logic pullup_transistor_off,
  output logic pulldown_transistor_off,
  // Channel count to the modulator
  output logic [`POMSR_CHAN_W-1:0] channels_per_comparison,
  output logic exact_freq_active,
  // Internal signals for the selector, code order
  input wire logic [31:0] mux_sources,
  // Status
  input wire logic lock_detect,
  input wire logic self_test_running,
  input wire logic [`POMSR_SIG_W-1:0] self_test_signature
);
  logic [`POMSR_CHAN_W-1:0] chan_r;
  logic [`POMSR_PINCTL_W-1:0] pinctl_r;
  logic gpo_r;
  logic lock_r;
  logic busy_r;
  logic [`POMSR_SIG_W-1:0] sig_r;
  logic [`POMSR_DATA_W-1:0] rdata_nxt;
  wire gpo_sel_value;
  wire pomsr_pkg::pomsr_sel_t sel;
  wire hold_dataout_mux;
  wire keep_driver;
  wire gpo_drive;
  wire wr_chan;
  wire wr_pinctl;

  function automatic logic hit(input pomsr_pkg::pomsr_addr_t a, input logic [4:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  assign wr_chan = reg_wr && hit(reg_addr, `POMSR_OFS_CHANNELS);
  assign wr_pinctl = reg_wr && hit(reg_addr, `POMSR_OFS_PINCTL);
  assign sel = pinctl_r[`POMSR_SEL_MSB:`POMSR_SEL_LSB];
  assign hold_dataout_mux = pinctl_r[`POMSR_HOLDMUX_BIT];
  assign keep_driver = pinctl_r[`POMSR_KEEPDRV_BIT];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      chan_r <= `POMSR_CHAN_RST;
    end else if (wr_chan) begin
      chan_r <= reg_wdata[`POMSR_CHAN_W-1:0];
    end
  end
  assign channels_per_comparison = chan_r;
  assign exact_freq_active = (chan_r > 14'h0001);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pinctl_r <= `POMSR_PINCTL_RST;
    end else if (wr_pinctl) begin
      pinctl_r <= reg_wdata[`POMSR_PINCTL_W-1:0];
    end
  end

  pomsr_source_mux u_mux (
    .sel(sel),
    .test_data(pinctl_r[`POMSR_TEST_BIT]),
    .sources(mux_sources),
    .selected(gpo_sel_value)
  );

  assign gpo_drive = !serial_rd_active && (gpo_enable || !hold_dataout_mux);
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dataout_o <= 1'b0;
    end else begin
      dataout_o <= serial_rd_active ? serial_dout : gpo_sel_value;
    end
  end
  // driver kept on when bit 7 set
  assign dataout_oe_n = !(serial_rd_active || gpo_drive || keep_driver);
  assign pullup_transistor_off = pinctl_r[`POMSR_PFET_BIT];
  assign pulldown_transistor_off = pinctl_r[`POMSR_NFET_BIT];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gpo_r <= 1'b0;
      lock_r <= 1'b0;
      busy_r <= 1'b0;
      sig_r <= 16'h0000;
    end else begin
      gpo_r <= gpo_sel_value;
      lock_r <= lock_detect;
      busy_r <= self_test_running;
      sig_r <= self_test_signature;
    end
  end

  always_comb begin
    rdata_nxt = '0;
    case (reg_addr)
      `POMSR_OFS_CHANNELS: rdata_nxt[`POMSR_CHAN_W-1:0] = chan_r;
      `POMSR_OFS_PINCTL: rdata_nxt[`POMSR_PINCTL_W-1:0] = pinctl_r;
      `POMSR_OFS_STATUS: rdata_nxt[1:0] = {lock_r, gpo_r};
      `POMSR_OFS_SELFTEST: rdata_nxt[`POMSR_BUSY_BIT:0] = {busy_r, sig_r};
      default: rdata_nxt = '0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= rdata_nxt;
    end
  end

  sequence s_rd_rsvd;
    reg_rd && (hit(reg_addr, `POMSR_OFS_RSVD_A) || hit(reg_addr, `POMSR_OFS_RSVD_B));
  endsequence

  chk_chan_write: assert property (@(posedge clk) disable iff (sys_rst)
    wr_chan |=> channels_per_comparison == $past(reg_wdata[13:0]))
    else $error("channel count not stored");
  chk_exact_enable: assert property (@(posedge clk) disable iff (sys_rst)
    exact_freq_active == (channels_per_comparison >= 14'h0002))
    else $error("exact mode enable wrong");
  chk_sel_route: assert property (@(posedge clk) disable iff (sys_rst)
    !serial_rd_active && sel != 5'h00 |=> dataout_o == $past(mux_sources[sel]))
    else $error("selector routing wrong");
  chk_test_bit: assert property (@(posedge clk) disable iff (sys_rst)
    !serial_rd_active && sel == 5'h00 |=> dataout_o == $past(pinctl_r[5]))
    else $error("test bit not on pin");
  chk_hold_mux: assert property (@(posedge clk) disable iff (sys_rst)
    hold_dataout_mux && !gpo_enable && !serial_rd_active && !keep_driver |-> dataout_oe_n)
    else $error("automux not held");
  chk_keep_drv: assert property (@(posedge clk) disable iff (sys_rst)
    keep_driver |-> !dataout_oe_n)
    else $error("driver disabled while kept");
  chk_rsvd_zero: assert property (@(posedge clk) disable iff (sys_rst)
    s_rd_rsvd |=> reg_rdata == '0)
    else $error("reserved register not zero");
  chk_status_read: assert property (@(posedge clk) disable iff (sys_rst)
    reg_rd && hit(reg_addr, `POMSR_OFS_STATUS) |=> reg_rdata[1] == $past(lock_r))
    else $error("lock status wrong");
  chk_busy_read: assert property (@(posedge clk) disable iff (sys_rst)
    reg_rd && hit(reg_addr, `POMSR_OFS_SELFTEST) |=> reg_rdata[16:0] == $past({busy_r, sig_r}))
    else $error("self-test readback wrong");

  sequence s_wr_pinctl;
    wr_pinctl;
  endsequence

  sequence s_rd_status;
    reg_rd && hit(reg_addr, `POMSR_OFS_STATUS);
  endsequence

  // Writes land next cycle, other cycles leave the fields alone
  chk_pinctl_write: assert property (@(posedge clk) disable iff (sys_rst)
    s_wr_pinctl |=> sel == $past(reg_wdata[4:0])
      && pullup_transistor_off == $past(reg_wdata[8])
      && pulldown_transistor_off == $past(reg_wdata[9]))
    else $error("pin control not stored");
  chk_chan_hold: assert property (@(posedge clk) disable iff (sys_rst)
    !wr_chan |=> $stable(channels_per_comparison))
    else $error("channel count changed without write");
  chk_sel_hold: assert property (@(posedge clk) disable iff (sys_rst)
    !wr_pinctl |=> $stable(sel))
    else $error("selector changed without write");

  // Read data stands until the next read strobe
  chk_rdata_stand: assert property (@(posedge clk) disable iff (sys_rst)
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without read");
  chk_gpo_read: assert property (@(posedge clk) disable iff (sys_rst)
    s_rd_status |=> reg_rdata[0] == $past(gpo_r) && reg_rdata[23:2] == 22'h000000)
    else $error("pin status wrong");
  chk_selftest_top: assert property (@(posedge clk) disable iff (sys_rst)
    reg_rd && hit(reg_addr, `POMSR_OFS_SELFTEST) |=> reg_rdata[23:17] == 7'h00)
    else $error("self-test upper bits not zero");

  // Pin is driven whenever it is a general output or automuxed
  chk_gpo_drive: assert property (@(posedge clk) disable iff (sys_rst)
    gpo_enable |-> !dataout_oe_n)
    else $error("general output not driven");
  chk_automux_on: assert property (@(posedge clk) disable iff (sys_rst)
    !hold_dataout_mux |-> !dataout_oe_n)
    else $error("automux not driving");
  chk_serial_pin: assert property (@(posedge clk) disable iff (sys_rst)
    serial_rd_active |=> dataout_o == $past(serial_dout))
    else $error("serial data not on pin");
endmodule : pomsr_regs
`default_nettype wire

// ---- pomsr_source_mux.sv ----
/*
  Selects the test bit (code 0) or one of 31 internal signals for the general output pin.
  Assumes all sources are already on the register clock.
*/
`timescale 1ns/1ns
`default_nettype none
module pomsr_source_mux (
  // Selection
  input wire pomsr_pkg::pomsr_sel_t sel,
  input wire logic test_data,
  // Sources
  input wire logic [31:0] sources,
  // Result
  output logic selected
);
  wire [31:0] muxed_sources;
  assign muxed_sources = {sources[31:1], test_data};
  assign selected = muxed_sources[sel];
endmodule : pomsr_source_mux
`default_nettype wire

// ---- tb_pll_output_mux_status_regs.sv ----
/*
  Self-checking bench for the register bank and pin selector.
  Assumes the host model drives the register strobes.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_pll_output_mux_status_regs;
  logic clk, sys_rst, srd, sdo, gen, od, oen, pu, pd, efa, lock, busy;
  logic reg_wr, reg_rd;
  pomsr_pkg::pomsr_addr_t reg_addr;
  pomsr_pkg::pomsr_data_t reg_wdata, reg_rdata, r;
  logic [13:0] cnt;
  logic [31:0] src;
  logic [15:0] sig;
  int fails = 0;
  int num_checks = 0;
  // Rows: selector code, pin with one-hot sources, pin with inverted sources
  logic [6:0] rows [20] = '{{5'h00, 2'b11}, {5'h01, 2'b10}, {5'h02, 2'b10},
    {5'h03, 2'b10}, {5'h04, 2'b10}, {5'h08, 2'b10}, {5'h09, 2'b10}, {5'h0a, 2'b10},
    {5'h0b, 2'b10}, {5'h0c, 2'b10}, {5'h10, 2'b10}, {5'h11, 2'b10}, {5'h14, 2'b10},
    {5'h15, 2'b10}, {5'h16, 2'b10}, {5'h17, 2'b10}, {5'h18, 2'b10}, {5'h19, 2'b10},
    {5'h1e, 2'b10}, {5'h1f, 2'b10}};
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  pomsr_host h (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  pomsr_regs dut (.clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .serial_rd_active(srd), .serial_dout(sdo), .gpo_enable(gen), .dataout_o(od),
    .dataout_oe_n(oen), .pullup_transistor_off(pu), .pulldown_transistor_off(pd),
    .channels_per_comparison(cnt), .exact_freq_active(efa), .mux_sources(src),
    .lock_detect(lock), .self_test_running(busy), .self_test_signature(sig));
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic end_of_test();
    if (fails == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test
  initial begin
    {sys_rst, srd, sdo, gen, src, lock, busy, sig} = {4'b1001, 32'h0, 2'b00, 16'h0};
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    h.rd(5'h0c, r); chk(r, 24'h0);
    h.rd(5'h0f, r); chk(r, 24'h1);
    h.rd(5'h12, r); chk(r, 24'h0);
    h.rd(5'h13, r); chk(r, 24'h0);
    // One-hot then inverted sources, test bit set in both phases
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      src <= (i < 20) ? (32'h1 << rows[i % 20][6:2]) : ~(32'h1 << rows[i % 20][6:2]);
      h.wr(5'h0f, {19'h00000, rows[i % 20][6:2]} | 24'h000060);
      repeat (2) @(posedge clk);
      #1 chk(od, (i < 20) ? rows[i % 20][1] : rows[i % 20][0]);
      chk(oen, 1'b0);
    end
    // largest ratio, modulator taken as mode B
    h.wr(5'h0c, 24'h3fff); h.rd(5'h0c, r); chk(r, 24'h3fff);
    chk(efa, 1'b1);
    h.wr(5'h0c, 24'h1); #1 chk(efa, 1'b0);
    h.wr(5'h0c, 24'h2); #1 chk(efa, 1'b1);
    // back to zero outside mode B
    h.wr(5'h0c, 24'h0); #1 chk(cnt, 24'h0);
    h.wr(5'h10, 24'hffffff); h.rd(5'h10, r); chk(r, 24'h0);
    h.wr(5'h11, 24'hffffff); h.rd(5'h11, r); chk(r, 24'h0);
    @(posedge clk);
    {lock, busy, sig} <= {2'b11, 16'hbeef};
    repeat (3) @(posedge clk);
    h.rd(5'h13, r); chk(r, 24'h1beef);
    h.rd(5'h12, r); chk(r, 24'h2);
    busy <= 1'b0;
    repeat (3) @(posedge clk);
    h.rd(5'h13, r); chk(r, 24'hbeef);
    h.wr(5'h0f, 24'h060); h.rd(5'h12, r); chk(r, 24'h3);
    src <= 32'hffffffff;
    h.wr(5'h0f, 24'h040);
    repeat (2) @(posedge clk);
    #1 chk(od, 1'b0);
    @(posedge clk);
    {gen, sdo} <= 2'b01;
    h.wr(5'h0f, 24'h340); #1 chk({pd, pu, oen}, 3'b111);
    h.wr(5'h0f, 24'h0c0); #1 chk({pd, pu, oen}, 3'b000);
    h.wr(5'h0f, 24'h000); #1 chk(oen, 1'b0);
    h.wr(5'h0f, 24'h040); #1 chk(oen, 1'b1);
    @(posedge clk);
    srd <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk({od, oen}, 2'b10);
    // Mid-run reset puts every register back
    h.wr(5'h0c, 24'h0055);
    sys_rst <= 1'b1;
    srd <= 1'b0;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    #1 chk({od, cnt}, 24'h0);
    chk(reg_rdata, 24'h0);
    h.rd(5'h0f, r); chk(r, 24'h1);
    end_of_test();
  end
endmodule : tb_pll_output_mux_status_regs
`default_nettype wire
